// file: src/sfs_engine.sv
`timescale 1ns/1ps
// Internal write, program and erase sequencer on the core clock.
module sfs_engine
  import sfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire sfs_pkg::sfs_req_t req_in,
  output logic busy_out,
  output logic [2:0] erase_kind_out,
  output logic prog_phase_out
);
  typedef enum logic [1:0] {SFS_IDLE, SFS_ERASE, SFS_PROG} sfs_eng_t;
  sfs_eng_t state_reg;
  logic [15:0] cnt_reg;
  sfs_job_t job_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= SFS_IDLE;
      cnt_reg <= 16'h0000;
      job_reg <= SFS_JOB_NONE;
    end else begin
      unique case (state_reg)
        SFS_IDLE: begin
          if (start_in && req_in.job != SFS_JOB_NONE) begin
            job_reg <= req_in.job;
            if (req_in.job == SFS_JOB_FILL) begin
              state_reg <= SFS_PROG;
              cnt_reg <= T_PROG_CYC;
            end else if (req_in.job == SFS_JOB_WRSR) begin
              state_reg <= SFS_PROG;
              cnt_reg <= T_WRSR_CYC;
            end else begin
              state_reg <= SFS_ERASE;
              cnt_reg <= T_ERASE_CYC;
            end
          end
        end
        SFS_ERASE: begin
          if (cnt_reg == 16'h0001) begin
            if (job_reg == SFS_JOB_REWRITE) begin
              state_reg <= SFS_PROG;
              cnt_reg <= T_PROG_CYC;
            end else begin
              state_reg <= SFS_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        SFS_PROG: begin
          if (cnt_reg == 16'h0001) begin
            state_reg <= SFS_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      erase_kind_out <= 3'h0;
      prog_phase_out <= 1'b0;
    end else begin
      busy_out <= (state_reg != SFS_IDLE) || (start_in && req_in.job != SFS_JOB_NONE);
      erase_kind_out <= (state_reg == SFS_ERASE) ? job_reg : 3'h0;
      prog_phase_out <= (state_reg == SFS_PROG);
    end
  end

  chk_rewrite_order: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SFS_ERASE && job_reg == SFS_JOB_REWRITE && cnt_reg == 16'h0001)
    |=> state_reg == SFS_PROG)
    else $error("rewrite erase not followed by program");
  chk_fill_no_erase: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SFS_IDLE && start_in && req_in.job == SFS_JOB_FILL)
    |=> state_reg == SFS_PROG)
    else $error("page fill went through an erase");
endmodule

// file: src/sfs_front.sv
`timescale 1ns/1ps
module sfs_front
  import sfs_pkg::*;
(
  // Core clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Serial link; the serial clock clocks the link logic.
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  // Device pins.
  input wire logic reset_n_in,
  input wire logic wp_n_in,
  // Status.
  output logic standby_out,
  output logic sleep_out,
  output logic cycle_active_out,
  output logic [2:0] protect_level_bits_out
);
  // Link side is cleared by deselect or device reset; it has no clock between frames.
  logic link_rst;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [5:0] byte_reg;
  logic [7:0] op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [BYTE_CNT_W-1:0] nbytes_reg;
  logic [7:0] wr_sr_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic armed_link;
  logic [7:0] status_link_reg;
  logic [7:0] status_link2_reg;
  logic [7:0] rx_byte;

  assign link_rst = sel_n_in | ~reset_n_in;
  assign rx_byte = {shift_reg[6:0], sdi_in};

  // Core side.
  logic sel_n_s;
  logic reset_n_s;
  logic wp_n_s;
  logic rst_core;
  logic armed_reg;
  logic sel_q_reg;
  logic busy;
  logic [2:0] ekind;
  logic pphase;
  logic start_reg;
  sfs_req_t req_reg;
  logic sleep_reg;
  logic wel_reg;
  logic srwd_reg;
  logic [2:0] bp_reg;
  logic [7:0] status_core;

  sfs_sync u_sync_sel (.clk_in(clk_in), .rst_in(rst_in), .d_in(~sel_n_in),
    .q_out(sel_n_s));
  sfs_sync u_sync_rst (.clk_in(clk_in), .rst_in(rst_in), .d_in(reset_n_in),
    .q_out(reset_n_s));
  sfs_sync u_sync_wp (.clk_in(clk_in), .rst_in(rst_in), .d_in(wp_n_in),
    .q_out(wp_n_s));

  assign rst_core = rst_in | ~reset_n_s;

  // Status byte is built in the core domain and reaches the link through two flops.
  always_comb begin
    status_core = 8'h00;
    status_core[SR_ACTIVE_BIT] = busy | start_reg;
    status_core[SR_WEL_BIT] = wel_reg;
    status_core[SR_BP_LSB +: 3] = bp_reg;
    status_core[SR_SRWD_BIT] = srwd_reg;
  end

  always_ff @(posedge sclk_in) begin
    status_link_reg <= status_core;
    status_link2_reg <= status_link_reg;
  end

  // The first select fall since device reset arms the link; it is a level once set.
  always_ff @(negedge sel_n_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      armed_link <= 1'b0;
    end else begin
      armed_link <= 1'b1;
    end
  end

  // Input shifting on rising serial clock only while selected.
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      byte_reg <= 6'h00;
      op_reg <= 8'h00;
      addr_reg <= '0;
      nbytes_reg <= '0;
      wr_sr_reg <= 8'h00;
    end else begin
      shift_reg <= rx_byte;
      bit_reg <= bit_reg + 3'h1;
      if (bit_reg == 3'h7) begin
        if (byte_reg != 6'h3f) begin
          byte_reg <= byte_reg + 6'h01;
        end
        unique case (byte_reg)
          6'h00: op_reg <= rx_byte;
          6'h01: addr_reg[23:16] <= rx_byte;
          6'h02: addr_reg[15:8] <= rx_byte;
          6'h03: addr_reg[7:0] <= rx_byte;
          default: ;
        endcase
        if (byte_reg == 6'h01 && op_reg == OP_WRSR) begin
          wr_sr_reg <= rx_byte;
        end
        if (byte_reg >= 6'h04 && nbytes_reg != PAGE_BYTES_MAX) begin
          nbytes_reg <= nbytes_reg + 9'h001;
        end
      end
    end
  end

  // Output data on falling serial clock.
  always_comb begin
    tx_next = {tx_reg[6:0], 1'b0};
    if (bit_reg == 3'h0 && byte_reg != 6'h00) begin
      unique case (op_reg)
        OP_RDSR: tx_next = status_link2_reg;
        OP_RDID: tx_next = (byte_reg == 6'h01) ? ID_CODE[15:8] : ID_CODE[7:0];
        default: tx_next = 8'h00;
      endcase
    end
  end

  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      tx_reg <= 8'h00;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // Frame capture at select rise: hand the request over with the level of select.
  sfs_req_t frame_req;
  always_comb begin
    frame_req = '0;
    frame_req.addr = addr_reg;
    frame_req.nbytes = nbytes_reg;
    frame_req.sr_value = wr_sr_reg;
    frame_req.job = SFS_JOB_NONE;
    if (bit_reg == 3'h0) begin
      unique case (op_reg)
        OP_PAGE_REWRITE: if (byte_reg >= 6'h05) frame_req.job = SFS_JOB_REWRITE;
        OP_PAGE_FILL: if (byte_reg >= 6'h05) frame_req.job = SFS_JOB_FILL;
        OP_PAGE_CLEAR: if (byte_reg == 6'h04) frame_req.job = SFS_JOB_PAGE;
        OP_SMALL_BLOCK_CLEAR: if (byte_reg == 6'h04) frame_req.job = SFS_JOB_SUB;
        OP_BLOCK_CLEAR: if (byte_reg == 6'h04) frame_req.job = SFS_JOB_SECTOR;
        OP_WHOLE_CLEAR: if (byte_reg == 6'h01) frame_req.job = SFS_JOB_WHOLE;
        OP_WRSR: if (byte_reg == 6'h02) frame_req.job = SFS_JOB_WRSR;
        default: frame_req.job = SFS_JOB_NONE;
      endcase
    end
  end

  // Held fields are stable while select is high, since the link is idle then.
  sfs_req_t hold_req_reg;
  logic [7:0] hold_op_reg;
  logic hold_complete_reg;
  always_ff @(posedge sel_n_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_req_reg <= '0;
      hold_op_reg <= 8'h00;
      hold_complete_reg <= 1'b0;
    end else begin
      hold_req_reg <= frame_req;
      hold_op_reg <= op_reg;
      hold_complete_reg <= armed_link && (bit_reg == 3'h0) && (byte_reg != 6'h00);
    end
  end

  // Core: select rise from the synchroniser launches the decoded frame.
  logic prot_hit;
  logic [SECTOR_MSB-SECTOR_LSB:0] sec_idx;
  logic [6:0] prot_count;
  assign sec_idx = hold_req_reg.addr[SECTOR_MSB:SECTOR_LSB];
  // Protected area counts whole sectors from the top of the array.
  // One bit wider than the sector count so the largest level covers the whole array.
  assign prot_count = (bp_reg == 3'h0) ? 7'h00 : (7'h01 << (bp_reg - 3'h1));
  assign prot_hit = (hold_req_reg.job == SFS_JOB_WHOLE) ? (bp_reg != 3'h0) :
    (({2'b00, sec_idx} + prot_count) >= 7'(SECTORS));

  always_ff @(posedge clk_in) begin
    if (rst_core) begin
      // Reset as if selected, so a select held low through reset is not taken as a fall.
      sel_q_reg <= 1'b1;
      armed_reg <= 1'b0;
      start_reg <= 1'b0;
      req_reg <= '0;
      sleep_reg <= 1'b0;
      wel_reg <= 1'b0;
    end else begin
      sel_q_reg <= sel_n_s;
      start_reg <= 1'b0;
      if (sel_n_s && !sel_q_reg) begin
        armed_reg <= 1'b1;
      end
      if (!sel_n_s && sel_q_reg && armed_reg && hold_complete_reg && !busy) begin
        if (sleep_reg) begin
          if (hold_op_reg == OP_WAKE) begin
            sleep_reg <= 1'b0;
          end
        end else if (hold_op_reg == OP_SLEEP_MODE) begin
          sleep_reg <= 1'b1;
        end else if (hold_op_reg == OP_WREN) begin
          wel_reg <= 1'b1;
        end else if (hold_op_reg == OP_WRDI) begin
          wel_reg <= 1'b0;
        end else if (hold_req_reg.job != SFS_JOB_NONE && wel_reg) begin
          wel_reg <= 1'b0;
          if (hold_req_reg.job == SFS_JOB_WRSR || !prot_hit) begin
            start_reg <= !(hold_req_reg.job == SFS_JOB_WRSR && srwd_reg && !wp_n_s);
            req_reg <= hold_req_reg;
          end
        end
      end
    end
  end

  // Protection bits survive device reset; only the core reset clears them.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bp_reg <= 3'h0;
      srwd_reg <= 1'b0;
    end else if (start_reg && req_reg.job == SFS_JOB_WRSR) begin
      bp_reg <= req_reg.sr_value[SR_BP_LSB+2:SR_BP_LSB];
      srwd_reg <= req_reg.sr_value[SR_SRWD_BIT];
    end
  end

  sfs_engine u_engine (
    .clk_in(clk_in),
    .rst_in(rst_core),
    .start_in(start_reg),
    .req_in(req_reg),
    .busy_out(busy),
    .erase_kind_out(ekind),
    .prog_phase_out(pphase)
  );

  // Pin drivers: link output level and enable with select and reset.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      standby_out <= 1'b0;
      sleep_out <= 1'b0;
      cycle_active_out <= 1'b0;
      protect_level_bits_out <= 3'h0;
    end else begin
      standby_out <= !sel_n_s && !busy && !start_reg && reset_n_s;
      sleep_out <= sleep_reg;
      cycle_active_out <= busy | start_reg;
      protect_level_bits_out <= bp_reg;
    end
  end

  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      sdo_out <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end else begin
      sdo_out <= tx_next[7];
      sdo_oe_n_out <= !armed_link;
    end
  end

  chk_standby_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    standby_out |-> !cycle_active_out)
    else $error("standby while cycle active");
  chk_active_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    busy |=> cycle_active_out)
    else $error("active flag missing during cycle");
  chk_sleep_gate: assert property (@(posedge clk_in) disable iff (rst_core)
    sleep_reg |=> !start_reg)
    else $error("cycle started while in sleep");
  chk_arm_first: assert property (@(posedge clk_in) disable iff (rst_core)
    !armed_reg |=> !start_reg)
    else $error("instruction taken before first select");
  chk_wp_freeze: assert property (@(posedge clk_in) disable iff (rst_in)
    (!wp_n_s && srwd_reg) |=> $stable(bp_reg))
    else $error("protect bits changed under write protect");
  chk_select_float: assert property (@(posedge sclk_in)
    sel_n_in |-> sdo_oe_n_out)
    else $error("output driven while deselected");
  chk_reset_float: assert property (@(posedge sclk_in)
    !reset_n_in |-> sdo_oe_n_out)
    else $error("output driven in reset mode");
  chk_count_cap: assert property (@(posedge sclk_in) disable iff (link_rst)
    nbytes_reg <= PAGE_BYTES_MAX)
    else $error("page byte count above limit");
  chk_erase_kind: assert property (@(posedge clk_in) disable iff (rst_core)
    (ekind != 3'h0) |-> (ekind == req_reg.job && ekind != SFS_JOB_FILL))
    else $error("erase kind differs from request");
  chk_prog_kind: assert property (@(posedge clk_in) disable iff (rst_core)
    pphase |-> (req_reg.job inside {SFS_JOB_REWRITE, SFS_JOB_FILL, SFS_JOB_WRSR}))
    else $error("program phase for an erase-only job");
endmodule

// file: src/sfs_pkg.sv
package sfs_pkg;

  // Array geometry.
  localparam int SECTORS = 32;
  localparam int SUBS_PER_SECTOR = 16;
  localparam int PAGES_PER_SECTOR = 256;
  localparam int PAGES_PER_SUB = 16;
  localparam int PAGE_BYTES = 256;
  localparam int ADDR_W = 24;
  localparam int SECTOR_MSB = 20;
  localparam int SECTOR_LSB = 16;
  localparam int SUB_LSB = 12;
  localparam int PAGE_LSB = 8;
  localparam int BYTE_CNT_W = 9;
  localparam logic [BYTE_CNT_W-1:0] PAGE_BYTES_MAX = 9'h100;

  // Instruction codes.
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_RDID = 8'h9f;
  localparam logic [7:0] OP_PAGE_REWRITE = 8'h0a;
  localparam logic [7:0] OP_PAGE_FILL = 8'h02;
  localparam logic [7:0] OP_PAGE_CLEAR = 8'hdb;
  localparam logic [7:0] OP_SMALL_BLOCK_CLEAR = 8'h20;
  localparam logic [7:0] OP_BLOCK_CLEAR = 8'hd8;
  localparam logic [7:0] OP_WHOLE_CLEAR = 8'hc7;
  localparam logic [7:0] OP_SLEEP_MODE = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;

  // Status register fields.
  localparam int SR_ACTIVE_BIT = 0;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_SRWD_BIT = 7;
  localparam logic [7:0] SR_WRITABLE = 8'h9c;

  // Arbitrary identity value.
  localparam logic [15:0] ID_CODE = 16'h5a3c;

  // Internal cycle durations in core clock cycles, kept small for bench use.
  localparam logic [15:0] T_ERASE_CYC = 16'h0040;
  localparam logic [15:0] T_PROG_CYC = 16'h0020;
  localparam logic [15:0] T_WRSR_CYC = 16'h0010;

  typedef enum logic [2:0] {
    SFS_JOB_NONE, SFS_JOB_REWRITE, SFS_JOB_FILL, SFS_JOB_PAGE,
    SFS_JOB_SUB, SFS_JOB_SECTOR, SFS_JOB_WHOLE, SFS_JOB_WRSR
  } sfs_job_t;

  // Request handed from the link domain to the core domain.
  typedef struct packed {
    sfs_job_t job;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_CNT_W-1:0] nbytes;
    logic [7:0] sr_value;
  } sfs_req_t;

endpackage

// file: src/sfs_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the output changes once stages two and three agree.
module sfs_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_out <= 1'b0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_out <= s3_reg;
      end
    end
  end
endmodule

// file: test/sfs_front_tb.sv
`timescale 1ns/1ps
module sfs_front_tb;
  import sfs_pkg::*;
  localparam int TE = int'(T_ERASE_CYC);
  localparam int TP = int'(T_PROG_CYC);
  localparam logic [63:0] OPS [6] = '{
    {OP_PAGE_REWRITE, 24'h000100, 32'h3c000000},
    {OP_PAGE_FILL, 24'h000200, 32'hc3000000},
    {OP_PAGE_CLEAR, 24'h000300, 32'h0},
    {OP_SMALL_BLOCK_CLEAR, 24'h001000, 32'h0},
    {OP_BLOCK_CLEAR, 24'h010000, 32'h0},
    {OP_WHOLE_CLEAR, 56'h0}};
  localparam int OPN [6] = '{5, 5, 4, 4, 4, 1};
  localparam int OPT [6] = '{TE + TP, TP, TE, TE, TE, TE};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reset_n = 1'b1;
  logic wp_n = 1'b1;
  logic sclk;
  logic sel_n;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic standby;
  logic sleep;
  logic active;
  logic [2:0] bp;
  logic [7:0] s;
  int fails = 0;
  int n_checks = 0;

  always #2 clk_in = ~clk_in;

  sfs_front uut (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .sel_n_in(sel_n), .sdi_in(sdi),
    .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n), .reset_n_in(reset_n), .wp_n_in(wp_n),
    .standby_out(standby), .sleep_out(sleep), .cycle_active_out(active),
    .protect_level_bits_out(bp)
  );

  sfs_master m (
    .sclk_out(sclk), .sel_n_out(sel_n), .sdi_out(sdi), .sdo_in(sdo),
    .sdo_oe_n_in(sdo_oe_n)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Cycle lengths get a little slack for the crossing; zero means refused.
  task automatic check_len(input string what, input int exp, input int got);
    n_checks++;
    if (exp == 0 ? got != 0 : (got < exp - 1 || got > exp + 8)) begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [63:0] tx, input int n);
    logic [7:0] rx;
    m.frame(tx, n, 0, rx);
  endtask

  task automatic run_len(output int len);
    len = 0;
    repeat (40) if (active !== 1'b1) @(negedge clk_in);
    if (active === 1'b1) check("standby in cycle", 8'h0, {7'h0, standby});
    while (active === 1'b1 && len < 2000) begin
      @(negedge clk_in);
      len++;
    end
  endtask

  task automatic wop(input string what, input logic [63:0] tx, input int n, input int exp);
    int len;
    cmd({OP_WREN, 56'h0}, 1);
    cmd(tx, n);
    run_len(len);
    check_len(what, exp, len);
  endtask

  task automatic t_powerup();
    repeat (10) @(negedge clk_in);
    check("standby selected", 8'h0, {7'h0, standby});
    cmd({OP_WREN, 56'h0}, 1);
    m.frame({OP_RDSR, 56'h0}, 1, 1, s);
    check("status no fall", 8'h00, s);
    check("oe while read", 8'h0, {7'h0, m.oe_hi});
    repeat (10) @(negedge clk_in);
    check("standby idle", 8'h1, {7'h0, standby});
    check("oe deselected", 8'h1, {7'h0, sdo_oe_n});
    $display("powerup done");
  endtask

  task automatic t_frames();
    int len;
    wop("fill no data", {OP_PAGE_FILL, 24'h000010, 32'h0}, 4, 0);
    for (int i = 0; i < 6; i++) begin
      wop("op length", OPS[i], OPN[i], OPT[i]);
    end
    cmd({OP_WRDI, 56'h0}, 1);
    cmd({OP_PAGE_CLEAR, 24'h000300, 32'h0}, 4);
    run_len(len);
    check_len("clear no wren", 0, len);
    $display("frames done");
  endtask

  task automatic t_sleep();
    cmd({OP_SLEEP_MODE, 56'h0}, 1);
    repeat (20) @(negedge clk_in);
    check("sleep on", 8'h1, {7'h0, sleep});
    wop("clear in sleep", {OP_PAGE_CLEAR, 24'h000300, 32'h0}, 4, 0);
    cmd({OP_WAKE, 56'h0}, 1);
    repeat (20) @(negedge clk_in);
    check("sleep off", 8'h0, {7'h0, sleep});
    $display("sleep done");
  endtask

  task automatic t_mode3();
    m.mode3 = 1'b1;
    cmd({OP_WREN, 56'h0}, 1);
    m.frame({OP_RDSR, 56'h0}, 1, 1, s);
    check("mode3 status", 8'h02, s);
    m.frame({OP_RDID, 56'h0}, 1, 1, s);
    check("mode3 id", ID_CODE[15:8], s);
    m.mode3 = 1'b0;
    $display("mode3 done");
  endtask

  task automatic t_protect();
    wop("wrsr", {OP_WRSR, 8'h84, 48'h0}, 2, int'(T_WRSR_CYC));
    check("level set", 8'h1, {5'h0, bp});
    m.frame({OP_RDSR, 56'h0}, 1, 1, s);
    check("status protect", 8'h84, s);
    @(negedge clk_in);
    wp_n = 1'b0;
    repeat (10) @(negedge clk_in);
    wop("wrsr frozen", {OP_WRSR, 8'h00, 48'h0}, 2, 0);
    check("level frozen", 8'h1, {5'h0, bp});
    wop("top sector", {OP_PAGE_CLEAR, 24'h1f0000, 32'h0}, 4, 0);
    wop("below top", {OP_PAGE_CLEAR, 24'h1eff00, 32'h0}, 4, TE);
    @(negedge clk_in);
    wp_n = 1'b1;
    $display("protect done");
  endtask

  task automatic t_reset();
    cmd({OP_WREN, 56'h0}, 1);
    cmd({OP_PAGE_CLEAR, 24'h000400, 32'h0}, 4);
    repeat (40) if (active !== 1'b1) @(negedge clk_in);
    reset_n = 1'b0;
    repeat (10) @(negedge clk_in);
    check("cycle aborted", 8'h0, {7'h0, active});
    m.frame({OP_RDSR, 56'h0}, 1, 1, s);
    check("oe in reset", 8'h1, {7'h0, m.oe_hi});
    @(negedge clk_in);
    reset_n = 1'b1;
    repeat (20) @(negedge clk_in);
    check("standby after", 8'h1, {7'h0, standby});
    $display("reset done");
  endtask

  // The run needs roughly two fifths of this span.
  initial begin
    #300us;
    fails++;
    $display("[FAIL] watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    // The device reset pin is held low through power-up, as a board would do.
    @(negedge clk_in);
    reset_n = 1'b0;
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    reset_n = 1'b1;
    t_powerup();
    t_frames();
    t_sleep();
    t_mode3();
    t_protect();
    t_reset();
    check("edge errors", 8'h0, 8'(m.edge_errs));
    print_verdict();
  end
endmodule

// file: test/sfs_master.sv
`timescale 1ns/1ps
// Bus master model, mode 0 or mode 3, MSB first; the clock is parked between frames.
module sfs_master (
  // Serial link driven by the master.
  output logic sclk_out,
  output logic sel_n_out,
  output logic sdi_out,
  // Returned by the device.
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in
);
  localparam realtime HALF = 80.0;
  logic mode3;
  logic oe_hi;
  int edge_errs;
  logic q_seen;

  // A floating output shows the inverse of its last level, so stale data cannot pass.
  assign q_seen = sdo_oe_n_in ? ~sdo_in : sdo_in;

  // Select comes up low, so the first frame starts without a select fall.
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b0;
    sdi_out = 1'b0;
    mode3 = 1'b0;
    oe_hi = 1'b0;
    edge_errs = 0;
  end

  task automatic frame(input logic [63:0] tx, input int n, input int nrd,
                       output logic [7:0] rx);
    logic r;
    sclk_out = mode3;
    #(4 * HALF);
    if (sel_n_out) begin
      sel_n_out = 1'b0;
      #(HALF);
    end
    oe_hi = 1'b1;
    for (int i = 0; i < 8 * (n + nrd); i++) begin
      sclk_out = 1'b0;
      sdi_out = (i < 8 * n) ? tx[63-i] : ~sdi_out;
      #(HALF);
      sclk_out = 1'b1;
      r = q_seen;
      if (i >= 8 * n) oe_hi &= sdo_oe_n_in;
      #(HALF / 2);
      if (q_seen !== r) edge_errs++;
      #(HALF / 2);
      rx = {rx[6:0], r};
    end
    if (!mode3) sclk_out = 1'b0;
    #(HALF);
    sel_n_out = 1'b1;
    // A released data line must not keep looking valid.
    sdi_out = ~sdi_out;
  endtask
endmodule
